/* File: pkg/irq_svc_pkg.sv */
/*
  Shared constants of the serial interrupt service pair: register indices, command codes,
  vector status codes, master control bit and the acknowledge settling time.
  Assumes one 125 MHz clock shared by both ends.
*/
package irq_svc_pkg;
  localparam int unsigned CLK_MHZ = 125;
  // Register indices on the link, selected by the 4-bit register pointer.
  localparam logic [3:0] REG_COMMAND = 4'h0;
  localparam logic [3:0] REG_RX_COND = 4'h1;
  localparam logic [3:0] REG_VECTOR = 4'h2;
  localparam logic [3:0] REG_MASTER = 4'h9;
  localparam logic [3:0] REG_DATA = 4'h8;
  // Command codes written to the command register.
  localparam logic [7:0] CMD_RESET_TX_IP = 8'h28;
  localparam logic [7:0] CMD_ERROR_RESET = 8'h30;
  // Master control register layout.
  localparam int unsigned MIE_BIT = 3;
  localparam logic [7:0] MASTER_RESET = 8'h00;
  localparam logic [7:0] VECTOR_RESET = 8'h00;
  // Status codes placed in vector bits 6:4.
  localparam logic [2:0] VS_NONE = 3'h0;
  localparam logic [2:0] VS_TX_EMPTY = 3'h1;
  localparam logic [2:0] VS_RX_FULL = 3'h2;
  localparam logic [2:0] VS_SPECIAL = 3'h3;
  localparam int unsigned VS_POS = 4;
  // Receive condition bits.
  localparam int unsigned RC_PARITY = 4;
  localparam int unsigned RC_OVERRUN = 5;
  localparam int unsigned RC_FRAMING = 6;
  // Acknowledge settling time.
  localparam int unsigned ACK_SETTLE_NS = 800;
  localparam int unsigned ACK_SETTLE_CYC = (ACK_SETTLE_NS * CLK_MHZ + 999) / 1000;
  // Controller registers.
  localparam logic [1:0] HREG_STATUS = 2'h0;
  localparam logic [1:0] HREG_MASK = 2'h1;
  localparam logic [1:0] HREG_VECTOR = 2'h2;
  localparam logic [1:0] HREG_CTRL = 2'h3;
  localparam logic [1:0] MASK_RESET = 2'h3;
endpackage

/* File: pkg/irq_link_if.sv */
/*
  Link between the serial controller end and the host end.
  Assumes both ends share clk; the host drives strobes, the device answers next cycle.
*/
`timescale 1ns/1ps
`default_nettype none
interface irq_link_if;
  logic [3:0] reg_sel;
  logic [7:0] wdata;
  logic wr_stb;
  logic rd_stb;
  logic [7:0] rdata;
  logic int_n;
  logic interrupt_ack_input;
  modport device (
    input reg_sel,
    input wdata,
    input wr_stb,
    input rd_stb,
    input interrupt_ack_input,
    output rdata,
    output int_n
  );
  modport host (
    output reg_sel,
    output wdata,
    output wr_stb,
    output rd_stb,
    output interrupt_ack_input,
    input rdata,
    input int_n
  );
endinterface
`default_nettype wire

/* File: verilog/ack_glue.sv */
/*
  Acknowledge glue: turns the two processor acknowledge pulses into the device acknowledge
  level and a vector read strobe after the settling time.
  Assumes ack pulses are synchronous one-cycle pulses.
*/
`timescale 1ns/1ps
`default_nettype none
module ack_glue
  import irq_svc_pkg::*;
#(
  parameter int unsigned SETTLE_CYC = ACK_SETTLE_CYC
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic cpu_interrupt_ack_strobe,
  output logic ack_level,
  output logic vec_rd
);
  typedef enum logic [1:0] {
    G_IDLE = 2'b00,
    G_SETTLE = 2'b01,
    G_WAIT2 = 2'b10
  } gstate_t;
  typedef struct packed {
    gstate_t st;
    logic [7:0] cnt;
    logic vec_rd;
  } gs_t;
  gs_t q, d;
  always_comb begin
    d = q;
    d.vec_rd = 1'b0;
    unique case (q.st)
      G_IDLE: begin
        if (cpu_interrupt_ack_strobe) begin
          d.st = G_SETTLE; // [RL10]
          d.cnt = 8'(SETTLE_CYC);
        end
      end
      G_SETTLE: begin
        if (q.cnt != 8'h00) begin
          d.cnt = q.cnt - 8'h01;
        end else begin
          d.st = G_WAIT2;
        end
      end
      G_WAIT2: begin
        if (cpu_interrupt_ack_strobe) begin
          d.vec_rd = 1'b1; // [RL11]
          d.st = G_IDLE;
        end
      end
      default: d.st = G_IDLE;
    endcase
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
  assign ack_level = (q.st != G_IDLE);
  assign vec_rd = q.vec_rd;
endmodule
`default_nettype wire

/* File: verilog/serial_irq_device.sv */
/*
  Device end: interrupt sources, vector status, pending clear commands and interrupt output.
  Assumes the serial engine reports character moves and receive errors as one-cycle pulses.
*/
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// RL1 - No transmit interrupt before first character written
// RL2 - Transmit interrupt each time buffer empties
// RL3 - Command 28H clears transmit pending
// RL4 - No transmit interrupts until new message
// RL5 - Vector read reports highest pending source
// RL6 - After clear, next source is reported
// RL7 - Host toggles master enable before return
// RL8 - Host checks receive condition before data
// RL9 - Command 30H clears special receive condition
// RL10 - Glue waits about 800 ns after acknowledge
// RL11 - Second acknowledge reads vector onto bus
// RL12 - Master enable bit gates interrupt output
// RL13 - Active-low output while enabled source pends
module serial_irq_device
  import irq_svc_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  irq_link_if.device link,
  output logic [7:0] tx_char,
  output logic tx_char_valid,
  input wire logic tx_shift_load,
  input wire logic rx_char_valid,
  input wire logic [7:0] rx_char,
  input wire logic rx_parity_err,
  input wire logic rx_overrun_err,
  input wire logic rx_framing_err,
  input wire logic tx_ie,
  input wire logic rx_ie
);
  typedef struct packed {
    logic [7:0] master;
    logic [7:0] vector;
    logic [7:0] rx_cond;
    logic [7:0] rx_data;
    logic [7:0] tx_buf;
    logic tx_full;
    logic tx_armed;
    logic tx_ip;
    logic rx_ip;
    logic sp_ip;
    logic [7:0] rdata;
  } dev_t;
  dev_t q, d;
  logic [2:0] vs;
  logic any_ip;
  always_comb begin
    // Fixed priority: special condition over receive over transmit.
    if (q.sp_ip) begin
      vs = VS_SPECIAL;
    end else if (q.rx_ip) begin
      vs = VS_RX_FULL;
    end else if (q.tx_ip) begin
      vs = VS_TX_EMPTY;
    end else begin
      vs = VS_NONE;
    end
  end
  assign any_ip = (q.tx_ip & tx_ie) | ((q.rx_ip | q.sp_ip) & rx_ie);
  always_comb begin
    d = q;
    if (link.wr_stb) begin
      unique case (link.reg_sel)
        REG_MASTER: d.master = link.wdata;
        REG_VECTOR: d.vector = link.wdata;
        REG_DATA: begin
          d.tx_buf = link.wdata;
          d.tx_full = 1'b1;
          d.tx_armed = 1'b1; // [RL1]
          d.tx_ip = 1'b0;
        end
        REG_COMMAND: begin
          if (link.wdata == CMD_RESET_TX_IP) begin
            d.tx_ip = 1'b0; // [RL3]
            d.tx_armed = 1'b0; // [RL4]
          end
          if (link.wdata == CMD_ERROR_RESET) begin
            d.sp_ip = 1'b0; // [RL9]
            d.rx_cond = 8'h00;
          end
        end
        default: ;
      endcase
    end
    if (link.rd_stb && link.reg_sel == REG_DATA) begin
      d.rx_ip = 1'b0;
    end
    if (tx_shift_load && q.tx_full) begin
      d.tx_full = 1'b0;
      // Set wins over a same-cycle clear so no empty event is lost.
      if (q.tx_armed || d.tx_armed) begin
        d.tx_ip = 1'b1; // [RL2]
      end
    end
    if (rx_char_valid) begin
      d.rx_data = rx_char;
      d.rx_ip = 1'b1;
      if (rx_parity_err | rx_overrun_err | rx_framing_err) begin
        d.sp_ip = 1'b1; // [RL9]
        d.rx_cond[RC_PARITY] = q.rx_cond[RC_PARITY] | rx_parity_err;
        d.rx_cond[RC_OVERRUN] = q.rx_cond[RC_OVERRUN] | rx_overrun_err;
        d.rx_cond[RC_FRAMING] = q.rx_cond[RC_FRAMING] | rx_framing_err;
      end
    end
    d.rdata = 8'h00;
    if (link.rd_stb || link.interrupt_ack_input) begin
      if (link.interrupt_ack_input) begin
        // Vector read during acknowledge carries the same status.
        d.rdata = {q.vector[7], vs, q.vector[3:0]}; // [RL11]
      end else begin
        unique case (link.reg_sel)
          REG_VECTOR: d.rdata = {q.vector[7], vs, q.vector[3:0]}; // [RL5] [RL6]
          REG_RX_COND: d.rdata = q.rx_cond;
          REG_DATA: d.rdata = q.rx_data;
          REG_MASTER: d.rdata = q.master;
          default: d.rdata = 8'h00;
        endcase
      end
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
      q.master <= MASTER_RESET;
      q.vector <= VECTOR_RESET;
    end else begin
      q <= d;
    end
  end
  assign link.rdata = q.rdata;
  assign link.int_n = ~(q.master[MIE_BIT] & any_ip); // [RL12] [RL13]
  assign tx_char = q.tx_buf;
  assign tx_char_valid = q.tx_full;
endmodule
`default_nettype wire

/* File: verilog/serial_irq_host.sv */
/*
  Host end: software-facing register port, interrupt status/mask, vector capture and
  acknowledge glue driving the link.
  Assumes software obeys one strobe per cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module serial_irq_host
  import irq_svc_pkg::*;
#(
  parameter int unsigned SETTLE_CYC = ACK_SETTLE_CYC
) (
  input wire logic clk,
  input wire logic arst_n,
  irq_link_if.host link,
  input wire logic [1:0] sw_addr,
  input wire logic [15:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [15:0] sw_rdata,
  output logic irq,
  input wire logic cpu_interrupt_ack_strobe
);
  typedef struct packed {
    logic [1:0] status;
    logic [1:0] mask;
    logic [7:0] vec;
    logic int_seen;
    logic vec_pend;
    logic vec_cap;
    logic rd_cap;
    logic [7:0] link_rdata;
    logic [15:0] rdata;
    logic [3:0] reg_sel;
    logic [7:0] wdata;
    logic wr_stb;
    logic rd_stb;
  } host_t;
  host_t q, d;
  logic ack_level;
  logic vec_rd;
  ack_glue #(.SETTLE_CYC(SETTLE_CYC)) u_glue (
    .clk(clk),
    .arst_n(arst_n),
    .cpu_interrupt_ack_strobe(cpu_interrupt_ack_strobe),
    .ack_level(ack_level),
    .vec_rd(vec_rd)
  );
  always_comb begin
    d = q;
    d.wr_stb = 1'b0;
    d.rd_stb = vec_rd; // [RL11]
    d.reg_sel = vec_rd ? REG_VECTOR : q.reg_sel;
    d.rdata = 16'h0000;
    // The device answers in the cycle after its strobe, so capture waits one more cycle.
    d.vec_pend = vec_rd;
    d.vec_cap = q.vec_pend;
    d.rd_cap = q.rd_stb;
    d.int_seen = ~link.int_n;
    if (sw_wr && !vec_rd) begin
      unique case (sw_addr)
        HREG_MASK: d.mask = sw_wdata[1:0];
        HREG_CTRL: begin
          // Command word: bit 15 selects read, 11:8 register, 7:0 data.
          d.reg_sel = sw_wdata[11:8];
          d.wdata = sw_wdata[7:0];
          d.wr_stb = ~sw_wdata[15];
          d.rd_stb = sw_wdata[15];
        end
        default: ;
      endcase
    end
    if (sw_rd) begin
      unique case (sw_addr)
        HREG_STATUS: begin
          d.rdata = {14'h0000, q.status};
          d.status = 2'b00;
        end
        HREG_MASK: d.rdata = {14'h0000, q.mask};
        HREG_VECTOR: d.rdata = {8'h00, q.vec};
        HREG_CTRL: d.rdata = {7'h00, ~link.int_n, q.link_rdata};
        default: d.rdata = 16'h0000;
      endcase
    end
    if (q.rd_cap) begin
      d.link_rdata = link.rdata;
    end
    // A fresh falling edge of the device output is caught here, so MASTER_INTERRUPT_ENABLE toggling matters.
    if (!link.int_n && !q.int_seen) begin
      d.status[0] = 1'b1; // [RL7]
    end
    if (q.vec_cap) begin
      d.vec = link.rdata;
      d.status[1] = 1'b1;
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
      q.mask <= MASK_RESET;
    end else begin
      q <= d;
    end
  end
  assign link.reg_sel = q.reg_sel;
  assign link.wdata = q.wdata;
  assign link.wr_stb = q.wr_stb;
  assign link.rd_stb = q.rd_stb;
  assign link.interrupt_ack_input = ack_level; // [RL10]
  assign sw_rdata = q.rdata;
  assign irq = |(q.status & q.mask);
endmodule
`default_nettype wire

/* File: tb/irq_svc_checker.sv */
/*
  Checker for the link between the serial interrupt device and its host end.
  Assumes it is instantiated beside the link and sees its signals as plain inputs.
*/
`timescale 1ns/1ps
`default_nettype none
module irq_svc_checker
  import irq_svc_pkg::*;
#(
  parameter int unsigned SETTLE_CYC = ACK_SETTLE_CYC
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [3:0] reg_sel,
  input wire logic [7:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [7:0] rdata,
  input wire logic int_n,
  input wire logic interrupt_ack_input
);
  typedef struct packed {logic master_interrupt_enable; logic tx_quiet; logic [7:0] ack_cnt;} mon_t;
  mon_t mon_q;
  mon_t mon_d;
  // The settle counter saturates rather than wraps, so a long settle never looks short.
  always_comb begin
    mon_d = mon_q;
    if (wr_stb && reg_sel == REG_MASTER) mon_d.master_interrupt_enable = wdata[MIE_BIT];
    if (wr_stb && reg_sel == REG_COMMAND && wdata == CMD_RESET_TX_IP) mon_d.tx_quiet = 1'b1;
    if (wr_stb && reg_sel == REG_DATA) mon_d.tx_quiet = 1'b0;
    if (!interrupt_ack_input) mon_d.ack_cnt = 8'h00;
    else if (mon_q.ack_cnt != 8'hff) mon_d.ack_cnt = mon_q.ack_cnt + 8'h01;
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) mon_q <= '{master_interrupt_enable: 1'b0, tx_quiet: 1'b1, ack_cnt: 8'h00};
    else mon_q <= mon_d;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_mie_clear_quiets: assert property (wr_stb && reg_sel == REG_MASTER && !wdata[MIE_BIT] |=> int_n)
    else $error("interrupt output active after master enable cleared");
  a_int_needs_mie: assert property (!mon_q.master_interrupt_enable |-> int_n)
    else $error("interrupt output active while master enable is off");
  a_vector_shows_source: assert property (rd_stb && reg_sel == REG_VECTOR && !int_n |=> rdata[VS_POS +: 3] != VS_NONE)
    else $error("vector read shows no source while interrupt active");
  a_tx_quiet_status: assert property (rd_stb && reg_sel == REG_VECTOR && mon_q.tx_quiet |=> rdata[VS_POS +: 3] != VS_TX_EMPTY)
    else $error("transmit source reported with no new message");
  a_idle_rdata_zero: assert property (!rd_stb && !interrupt_ack_input |=> rdata == 8'h00)
    else $error("read data driven without a read");
  a_ack_settles: assert property ($fell(interrupt_ack_input) |-> mon_q.ack_cnt >= SETTLE_CYC)
    else $error("acknowledge released before settling time");
  a_ack_reads_vector: assert property ($fell(interrupt_ack_input) |-> ##[0:1] (rd_stb && reg_sel == REG_VECTOR))
    else $error("second acknowledge did not read the vector");
  a_strobe_exclusive: assert property (rd_stb |-> !wr_stb)
    else $error("read and write strobes together");
  cover property ($fell(interrupt_ack_input));
  cover property (rd_stb && reg_sel == REG_VECTOR ##1 rdata[VS_POS +: 3] == VS_SPECIAL);
  cover property (wr_stb && reg_sel == REG_COMMAND && wdata == CMD_RESET_TX_IP);
endmodule
`default_nettype wire

/* File: tb/serial_ctrl_interrupt_service_test.sv */
/*
  Bench for the serial interrupt service pair: software port, engine pulses and acknowledges.
  Assumes the package, link and both ends are compiled first; settle time shortened to 3.
*/
`timescale 1ns/1ps
`default_nettype none
module serial_ctrl_interrupt_service_test;
  import irq_svc_pkg::*;
  logic clk = 0, arst_n = 0, sw_wr = 0, sw_rd = 0, irq, ack = 0, tx_char_valid;
  logic tx_shift_load = 0, rx_char_valid = 0, tx_ie = 0, rx_ie = 0;
  logic [1:0] sw_addr = '0;
  logic [15:0] sw_wdata = '0, sw_rdata, d;
  logic [7:0] rx_char = '0, tx_char;
  logic [2:0] err = '0;
  int mismatches = 0, samples_checked = 0;
  irq_link_if link();
  always #4 clk = ~clk;
  serial_irq_device i_serial_irq_device(.clk(clk), .arst_n(arst_n), .link(link), .tx_char(tx_char),
    .tx_char_valid(tx_char_valid), .tx_shift_load(tx_shift_load), .rx_char_valid(rx_char_valid),
    .rx_char(rx_char), .rx_parity_err(err[0]), .rx_overrun_err(err[1]), .rx_framing_err(err[2]),
    .tx_ie(tx_ie), .rx_ie(rx_ie));
  serial_irq_host #(.SETTLE_CYC(3)) i_serial_irq_host(.clk(clk), .arst_n(arst_n), .link(link),
    .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata),
    .irq(irq), .cpu_interrupt_ack_strobe(ack));
  irq_svc_checker #(.SETTLE_CYC(3)) i_irq_svc_checker(.clk(clk), .arst_n(arst_n), .reg_sel(link.reg_sel),
    .wdata(link.wdata), .wr_stb(link.wr_stb), .rd_stb(link.rd_stb), .rdata(link.rdata), .int_n(link.int_n),
    .interrupt_ack_input(link.interrupt_ack_input));
  task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic sw(input logic [1:0] a, input logic [15:0] v, input logic rd);
    @(posedge clk);
    sw_addr <= a;
    sw_wdata <= v;
    sw_wr <= !rd;
    sw_rd <= rd;
    @(posedge clk);
    sw_wr <= 1'b0;
    sw_rd <= 1'b0;
    #1 d = sw_rdata;
  endtask
  // Each link access goes through the control register, so its result lags by a few cycles.
  task automatic lk(input logic [3:0] r, input logic [7:0] v, input logic rd);
    sw(HREG_CTRL, {rd, 3'h0, r, v}, 1'b0);
    repeat (3) @(posedge clk);
    sw(HREG_CTRL, 16'h0000, 1'b1);
  endtask
  task automatic vec(input string what, input logic [8:0] exp);
    lk(REG_VECTOR, 8'h00, 1'b1);
    check(what, d[8:0], exp);
  endtask
  task automatic load;
    @(posedge clk);
    tx_shift_load <= 1'b1;
    @(posedge clk);
    tx_shift_load <= 1'b0;
  endtask
  task automatic pulse_ack;
    @(posedge clk);
    ack <= 1'b1;
    @(posedge clk);
    ack <= 1'b0;
    repeat (8) @(posedge clk);
    #1;
  endtask
  task automatic results;
    $display("checks %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    #500us;
    mismatches++;
    results();
  end
  initial begin
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    tx_ie <= 1'b1;
    rx_ie <= 1'b1;
    lk(REG_MASTER, 8'h08, 1'b0);
    lk(REG_VECTOR, 8'h81, 1'b0);
    vec("idle vector", 9'h081);
    lk(REG_DATA, 8'ha5, 1'b0);
    check("tx buffer", {tx_char_valid, tx_char}, 9'h1a5);
    vec("vector before move", 9'h081);
    load();
    vec("first tx vector", 9'h191);
    lk(REG_DATA, 8'h5a, 1'b0);
    vec("tx rearmed", 9'h081);
    load();
    vec("second tx vector", 9'h191);
    lk(REG_COMMAND, CMD_RESET_TX_IP, 1'b0);
    vec("tx cleared", 9'h081);
    load();
    vec("tx stays quiet", 9'h081);
    lk(REG_DATA, 8'h11, 1'b0);
    load();
    sw(HREG_MASK, 16'h0000, 1'b0);
    lk(REG_MASTER, 8'h00, 1'b0);
    sw(HREG_STATUS, 16'h0000, 1'b1);
    sw(HREG_CTRL, 16'h0000, 1'b1);
    check("master off", {d[8], 8'h00}, 9'h000);
    lk(REG_MASTER, 8'h08, 1'b0);
    vec("master on", 9'h191);
    check("irq masked", {8'h00, irq}, 9'h000);
    sw(HREG_MASK, 16'h0003, 1'b0);
    #8;
    check("irq on edge", {8'h00, irq}, 9'h001);
    sw(HREG_STATUS, 16'h0000, 1'b1);
    check("edge status", {7'h00, d[1:0]}, 9'h001);
    #8;
    check("irq cleared", {8'h00, irq}, 9'h000);
    for (int k = 0; k < 3; k++) begin
      @(posedge clk);
      rx_char <= 8'h30 + 8'(k);
      rx_char_valid <= 1'b1;
      err <= 3'b001 << k;
      @(posedge clk);
      rx_char_valid <= 1'b0;
      err <= 3'b000;
      lk(REG_RX_COND, 8'h00, 1'b1);
      check("rx condition", {1'b0, d[7:0] & 8'h70}, {1'b0, 8'h10 << k});
      vec("special vector", 9'h1b1);
      lk(REG_COMMAND, CMD_ERROR_RESET, 1'b0);
      vec("rx after error reset", 9'h1a1);
      lk(REG_DATA, 8'h00, 1'b1);
      check("rx char", {1'b0, d[7:0]}, {1'b0, 8'h30 + 8'(k)});
      vec("tx next", 9'h191);
    end
    pulse_ack();
    pulse_ack();
    sw(HREG_VECTOR, 16'h0000, 1'b1);
    check("ack vector", {1'b0, d[7:0]}, 9'h091);
    sw(HREG_STATUS, 16'h0000, 1'b1);
    check("vector captured", {8'h00, d[1]}, 9'h001);
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    vec("vector after reset", 9'h000);
    results();
  end
endmodule
`default_nettype wire
